/* src/sdsp_pin_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
module sdsp_pin_ctrl (
   input wire logic ref_clk, // 10 MHz system clock
   input wire logic sys_rst, // Synchronous reset, active high
   input wire logic cmd_valid, // Command offered
   input wire logic [sdsp_pkg::OP_W-1:0] cmd_op, // Command code
   input wire logic [sdsp_pkg::PORT_W-1:0] cmd_port, // Digital port number
   input wire logic [sdsp_pkg::LINE_W-1:0] cmd_line, // Line or chip-select number
   input wire logic [sdsp_pkg::DIO_WIDTH-1:0] cmd_value, // Write value or direction byte
   input wire logic [sdsp_pkg::SPI_W-1:0] cmd_spi_sel, // Serial port chosen for the script
   output logic cmd_ready_ff, // Ready to take a command
   output logic cmd_done_ff, // Command finished, one cycle
   output logic cmd_error_ff, // Command rejected, with done
   output logic [sdsp_pkg::DIO_PORTS*sdsp_pkg::DIO_WIDTH-1:0] dio_out_ff, // Digital port levels
   output logic [sdsp_pkg::DIO_PORTS*sdsp_pkg::DIO_WIDTH-1:0] dio_oe_ff, // Digital port enables
   output logic [sdsp_pkg::SPI_PORTS-1:0] sclk_o_ff, // Serial clock levels
   output logic [sdsp_pkg::SPI_PORTS-1:0] sclk_oe_ff, // Serial clock enables
   output logic [sdsp_pkg::SPI_PORTS-1:0] mosi_o_ff, // Serial data out levels
   output logic [sdsp_pkg::SPI_PORTS-1:0] mosi_oe_ff, // Serial data out enables
   output logic [sdsp_pkg::CS_COUNT-1:0] cs_o_ff, // Chip-select levels
   output logic [sdsp_pkg::CS_COUNT-1:0] cs_oe_ff // Chip-select enables
);
   import sdsp_pkg::*;
   sdsp_state_type state_ff;
   sdsp_state_type nxt_state;
   logic [OP_W-1:0] op_ff;
   logic [OP_W-1:0] nxt_op;
   logic [PORT_W-1:0] port_ff;
   logic [PORT_W-1:0] nxt_port;
   logic [LINE_W-1:0] line_ff;
   logic [LINE_W-1:0] nxt_line;
   logic [DIO_WIDTH-1:0] value_ff;
   logic [DIO_WIDTH-1:0] nxt_value;
   logic [SPI_W-1:0] spi_ff;
   logic [SPI_W-1:0] nxt_spi;
   logic nxt_ready;
   logic nxt_done;
   logic nxt_error;
   logic [SPI_PORTS-1:0] nxt_sclk_o;
   logic [SPI_PORTS-1:0] nxt_sclk_oe;
   logic [SPI_PORTS-1:0] nxt_mosi_o;
   logic [SPI_PORTS-1:0] nxt_mosi_oe;
   logic [CS_COUNT-1:0] nxt_cs_o;
   logic [CS_COUNT-1:0] nxt_cs_oe;
   logic take;
   logic exec;
   logic dio_op;
   logic bad_cmd;
   logic [DIO_PORTS-1:0] port_upd;

   assign take = cmd_valid && cmd_ready_ff;
   assign exec = (state_ff == ST_EXEC);
   assign dio_op = (op_ff == OP_WR_LINE) || (op_ff == OP_WR_PORT) || (op_ff == OP_CFG_PORT);
   // Out-of-range port and unknown codes still complete, so a script never hangs
   assign bad_cmd = (op_ff > OP_CS_WR) || (dio_op && (port_ff >= PORT_LIMIT));

   // Sequencer: one command latched, applied next cycle, then the next one is taken
   always_comb begin
      nxt_state = state_ff;
      nxt_op = op_ff;
      nxt_port = port_ff;
      nxt_line = line_ff;
      nxt_value = value_ff;
      nxt_spi = spi_ff;
      nxt_done = 1'b0;
      nxt_error = 1'b0;
      case (state_ff)
         ST_IDLE: begin
            if (take) begin
               nxt_state = ST_EXEC;
               nxt_op = cmd_op;
               nxt_port = cmd_port;
               nxt_line = cmd_line;
               nxt_value = cmd_value;
               nxt_spi = cmd_spi_sel;
            end
         end
         ST_EXEC: begin
            nxt_state = ST_IDLE;
            nxt_done = 1'b1;
            nxt_error = bad_cmd;
         end
         default: begin
            nxt_state = ST_IDLE;
         end
      endcase
      nxt_ready = (nxt_state == ST_IDLE);
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         state_ff <= ST_IDLE;
         op_ff <= OP_WR_LINE;
         port_ff <= '0;
         line_ff <= '0;
         value_ff <= OUT_RST;
         spi_ff <= '0;
         cmd_ready_ff <= 1'b0;
         cmd_done_ff <= 1'b0;
         cmd_error_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         op_ff <= nxt_op;
         port_ff <= nxt_port;
         line_ff <= nxt_line;
         value_ff <= nxt_value;
         spi_ff <= nxt_spi;
         cmd_ready_ff <= nxt_ready;
         cmd_done_ff <= nxt_done;
         cmd_error_ff <= nxt_error;
      end
   end

   // One byte-wide port per instance; only the addressed port sees the strobe
   for (genvar p = 0; p < DIO_PORTS; p++) begin : g_port
      assign port_upd[p] = exec && dio_op && (port_ff == PORT_W'(p));
      sdsp_dio_port u_port (
         .ref_clk(ref_clk),
         .sys_rst(sys_rst),
         .upd_en(port_upd[p]),
         .upd_op(op_ff),
         .upd_line(line_ff),
         .upd_value(value_ff),
         .dir_ff(dio_oe_ff[p*DIO_WIDTH +: DIO_WIDTH]),
         .out_ff(dio_out_ff[p*DIO_WIDTH +: DIO_WIDTH])
      );
   end

   // Serial pin and chip-select state; no data exchange here, so master pins rest at idle levels
   always_comb begin
      nxt_sclk_o = sclk_o_ff;
      nxt_sclk_oe = sclk_oe_ff;
      nxt_mosi_o = mosi_o_ff;
      nxt_mosi_oe = mosi_oe_ff;
      nxt_cs_o = cs_o_ff;
      nxt_cs_oe = cs_oe_ff;
      if (exec) begin
         case (op_ff)
            OP_SPI_DIS: begin
               nxt_sclk_oe[spi_ff] = 1'b0;
               nxt_mosi_oe[spi_ff] = 1'b0;
               nxt_cs_oe = CS_NONE;
            end
            OP_SPI_EN: begin
               nxt_sclk_o[spi_ff] = SCLK_IDLE;
               nxt_mosi_o[spi_ff] = MOSI_IDLE;
               nxt_sclk_oe[spi_ff] = 1'b1;
               nxt_mosi_oe[spi_ff] = 1'b1;
               nxt_cs_o = {CS_COUNT{CS_EN_LEVEL}};
               nxt_cs_oe = CS_ALL;
            end
            OP_CS_WR: begin
               // Level only; a select still tristated stays so until enable
               nxt_cs_o[line_ff] = value_ff[0];
            end
            default: begin
               nxt_cs_o = cs_o_ff;
            end
         endcase
      end
   end

   // Everything starts tristated, the same as after disabling both serial ports
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         sclk_o_ff <= {SPI_PORTS{SCLK_IDLE}};
         sclk_oe_ff <= SPI_NONE;
         mosi_o_ff <= {SPI_PORTS{MOSI_IDLE}};
         mosi_oe_ff <= SPI_NONE;
         cs_o_ff <= {CS_COUNT{CS_EN_LEVEL}};
         cs_oe_ff <= CS_NONE;
      end else begin
         sclk_o_ff <= nxt_sclk_o;
         sclk_oe_ff <= nxt_sclk_oe;
         mosi_o_ff <= nxt_mosi_o;
         mosi_oe_ff <= nxt_mosi_oe;
         cs_o_ff <= nxt_cs_o;
         cs_oe_ff <= nxt_cs_oe;
      end
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (sys_rst);

   property p_dis_spi;
      (exec && op_ff == OP_SPI_DIS) |=>
         !sclk_oe_ff[$past(spi_ff)] && !mosi_oe_ff[$past(spi_ff)];
   endproperty
   a_dis_spi: assert property (p_dis_spi) else $error("serial pins not tristated");

   property p_dis_cs;
      (exec && op_ff == OP_SPI_DIS) |=> cs_oe_ff == CS_NONE;
   endproperty
   a_dis_cs: assert property (p_dis_cs) else $error("chip selects not tristated");

   property p_en_spi;
      (exec && op_ff == OP_SPI_EN) |=> sclk_oe_ff[$past(spi_ff)] && mosi_oe_ff[$past(spi_ff)] &&
         sclk_o_ff[$past(spi_ff)] == SCLK_IDLE;
   endproperty
   a_en_spi: assert property (p_en_spi) else $error("serial pins not enabled");

   property p_en_cs;
      (exec && op_ff == OP_SPI_EN) |=> cs_oe_ff == CS_ALL && cs_o_ff == CS_ALL;
   endproperty
   a_en_cs: assert property (p_en_cs) else $error("chip selects not driven high");

   property p_order;
      take |=> !cmd_ready_ff ##1 (cmd_done_ff && cmd_ready_ff);
   endproperty
   a_order: assert property (p_order) else $error("command timing wrong");

   property p_quiet;
      !exec |=> $stable(cs_oe_ff) && $stable(cs_o_ff) && $stable(sclk_oe_ff) && $stable(dio_out_ff);
   endproperty
   a_quiet: assert property (p_quiet) else $error("pins changed without a command");

   property p_addr_port;
      (exec && dio_op && port_ff >= PORT_LIMIT) |=> $stable(dio_out_ff) && $stable(dio_oe_ff) && cmd_error_ff;
   endproperty
   a_addr_port: assert property (p_addr_port) else $error("bad port not rejected");

   c_enable: cover property (exec && op_ff == OP_SPI_EN);
   c_disable: cover property (exec && op_ff == OP_SPI_DIS ##1 cs_oe_ff == CS_NONE);
   c_line: cover property (exec && op_ff == OP_WR_LINE && port_ff == '0);
   c_port_back: cover property (take && cmd_op == OP_WR_PORT ##2 take);
endmodule
`default_nettype wire

/* src/sdsp_pkg.sv */
// Contract
// - Single-line write drives the chosen line high for value 1, low for 0.
// - Single-line write changes only the chosen line; others keep their state.
// - Whole-port write applies one byte across all output lines of the port at once.
// - Whole-port write updates output lines only; input lines ignore their bits.
// - Disable command tristates every signal pin of the chosen serial port.
// - Disable command also tristates every chip-select output.
// - Enable command gives the chosen serial port pins their master function.
// - Enable command makes every chip select a push-pull output driven high.
// - Direction bit 1 makes the line an output, bit 0 an input.
`default_nettype none
package sdsp_pkg;
   // Port geometry
   localparam int DIO_WIDTH = 8;
   localparam int LINE_W = 3;
   localparam int DIO_PORTS = 2;
   localparam int PORT_W = 2;
   localparam int SPI_PORTS = 2;
   localparam int SPI_W = 1;
   localparam int CS_COUNT = 8;
   localparam int OP_W = 3;
   // Command codes
   localparam logic [OP_W-1:0] OP_WR_LINE = 3'h0;
   localparam logic [OP_W-1:0] OP_WR_PORT = 3'h1;
   localparam logic [OP_W-1:0] OP_CFG_PORT = 3'h2;
   localparam logic [OP_W-1:0] OP_SPI_DIS = 3'h3;
   localparam logic [OP_W-1:0] OP_SPI_EN = 3'h4;
   localparam logic [OP_W-1:0] OP_CS_WR = 3'h5;
   // Limits and reset values
   localparam logic [PORT_W-1:0] PORT_LIMIT = 2'h2;
   localparam logic [DIO_WIDTH-1:0] DIO_ONE = 8'h01;
   localparam logic [DIO_WIDTH-1:0] DIO_ALL = 8'hFF;
   localparam logic [DIO_WIDTH-1:0] DIR_RST = 8'h00;
   localparam logic [DIO_WIDTH-1:0] OUT_RST = 8'h00;
   localparam logic [CS_COUNT-1:0] CS_ALL = 8'hFF;
   localparam logic [CS_COUNT-1:0] CS_NONE = 8'h00;
   localparam logic [SPI_PORTS-1:0] SPI_NONE = 2'h0;
   localparam logic SCLK_IDLE = 1'b0;
   localparam logic MOSI_IDLE = 1'b0;
   localparam logic CS_EN_LEVEL = 1'b1;
   // Command sequencer states, one-hot
   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_EXEC = 2'b10
   } sdsp_state_type;
   // One-hot mask of a line within a byte
   function automatic logic [DIO_WIDTH-1:0] line_mask(input logic [LINE_W-1:0] line);
      line_mask = DIO_ONE << line;
   endfunction
endpackage
`default_nettype wire

/* src/sdsp_dio_port.sv */
`timescale 1ns/1ps
`default_nettype none
module sdsp_dio_port (
   input wire logic ref_clk, // System clock
   input wire logic sys_rst, // Synchronous reset, active high
   input wire logic upd_en, // One-cycle update strobe
   input wire logic [sdsp_pkg::OP_W-1:0] upd_op, // Operation code
   input wire logic [sdsp_pkg::LINE_W-1:0] upd_line, // Line number
   input wire logic [sdsp_pkg::DIO_WIDTH-1:0] upd_value, // Data or direction byte
   output logic [sdsp_pkg::DIO_WIDTH-1:0] dir_ff, // Direction, 1 is output
   output logic [sdsp_pkg::DIO_WIDTH-1:0] out_ff // Output latch
);
   import sdsp_pkg::*;
   logic [DIO_WIDTH-1:0] nxt_dir;
   logic [DIO_WIDTH-1:0] nxt_out;
   logic [DIO_WIDTH-1:0] sel;

   // Next latch and direction; line write stores even on an input line so it shows once turned to output
   always_comb begin
      sel = line_mask(upd_line);
      nxt_dir = dir_ff;
      nxt_out = out_ff;
      if (upd_en) begin
         case (upd_op)
            OP_WR_LINE: begin
               nxt_out = (out_ff & ~sel) | ({DIO_WIDTH{upd_value[0]}} & sel);
            end
            OP_WR_PORT: begin
               nxt_out = (upd_value & dir_ff) | (out_ff & ~dir_ff);
            end
            OP_CFG_PORT: begin
               nxt_dir = upd_value;
            end
            default: begin
               nxt_out = out_ff;
            end
         endcase
      end
   end

   // Registers; all lines start as inputs so nothing fights the wiring
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         dir_ff <= DIR_RST;
         out_ff <= OUT_RST;
      end else begin
         dir_ff <= nxt_dir;
         out_ff <= nxt_out;
      end
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (sys_rst);

   property p_line_level;
      (upd_en && upd_op == OP_WR_LINE) |=> out_ff[$past(upd_line)] == $past(upd_value[0]);
   endproperty
   a_line_level: assert property (p_line_level) else $error("line write level wrong");

   property p_line_only;
      (upd_en && upd_op == OP_WR_LINE) |=>
         ((out_ff ^ $past(out_ff)) & ~line_mask($past(upd_line))) == OUT_RST;
   endproperty
   a_line_only: assert property (p_line_only) else $error("line write touched other lines");

   property p_port_all;
      (upd_en && upd_op == OP_WR_PORT && dir_ff == DIO_ALL) |=> out_ff == $past(upd_value);
   endproperty
   a_port_all: assert property (p_port_all) else $error("port write did not apply byte");

   property p_port_inputs;
      (upd_en && upd_op == OP_WR_PORT) |=>
         ((out_ff ^ $past(out_ff)) & ~$past(dir_ff)) == OUT_RST &&
         ((out_ff ^ $past(upd_value)) & $past(dir_ff)) == OUT_RST;
   endproperty
   a_port_inputs: assert property (p_port_inputs) else $error("port write masking wrong");

   property p_dir_cfg;
      (upd_en && upd_op == OP_CFG_PORT) |=> dir_ff == $past(upd_value) && $stable(out_ff);
   endproperty
   a_dir_cfg: assert property (p_dir_cfg) else $error("direction not configured");
endmodule
`default_nettype wire

/* verification/sdsp_pin_model.sv */
`timescale 1ns/1ps
`default_nettype none
module sdsp_pin_model (
   input wire logic ref_clk, // System clock
   input wire logic [sdsp_pkg::DIO_PORTS*sdsp_pkg::DIO_WIDTH-1:0] dio_out, // Digital levels from the block
   input wire logic [sdsp_pkg::DIO_PORTS*sdsp_pkg::DIO_WIDTH-1:0] dio_oe, // Digital enables from the block
   input wire logic [sdsp_pkg::CS_COUNT-1:0] cs_out, // Chip-select levels from the block
   input wire logic [sdsp_pkg::CS_COUNT-1:0] cs_oe, // Chip-select enables from the block
   output logic [sdsp_pkg::DIO_PORTS*sdsp_pkg::DIO_WIDTH-1:0] dio_pin, // Resolved digital wires
   output logic [sdsp_pkg::CS_COUNT-1:0] cs_pin // Resolved chip-select wires
);
   import sdsp_pkg::*;
   logic float_ff;
   // Undriven wires flip every cycle, so a stale level can never pass for a driven one
   always_ff @(posedge ref_clk) begin
      float_ff <= (float_ff === 1'b1) ? 1'b0 : 1'b1;
   end
   // Each wire follows its driver only while the enable is high
   always_comb begin
      for (int i = 0; i < DIO_PORTS*DIO_WIDTH; i++) begin
         dio_pin[i] = dio_oe[i] ? dio_out[i] : float_ff;
      end
      for (int i = 0; i < CS_COUNT; i++) begin
         cs_pin[i] = cs_oe[i] ? cs_out[i] : float_ff;
      end
   end
endmodule
`default_nettype wire

/* verification/sdsp_pin_ctrl_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, got, exp) begin check_count++; if ((got) !== (exp)) begin n_errors++; $display("Error %s expected %h seen %h", nm, exp, got); end end
module sdsp_pin_ctrl_tb_top;
   import sdsp_pkg::*;
   logic ref_clk, sys_rst, cmd_valid, cmd_spi_sel;
   logic [OP_W-1:0] cmd_op;
   logic [PORT_W-1:0] cmd_port;
   logic [LINE_W-1:0] cmd_line;
   logic [DIO_WIDTH-1:0] cmd_value;
   logic cmd_ready_ff, cmd_done_ff, cmd_error_ff;
   logic [DIO_PORTS*DIO_WIDTH-1:0] dio_out_ff, dio_oe_ff, dio_pin, e_out, e_dir;
   logic [SPI_PORTS-1:0] sclk_o_ff, sclk_oe_ff, mosi_o_ff, mosi_oe_ff, e_sck_oe;
   logic [CS_COUNT-1:0] cs_o_ff, cs_oe_ff, cs_pin, e_cs_o, e_cs_oe;
   int n_errors = 0;
   int check_count = 0;
   int cycles = 0;
   sdsp_pin_ctrl sdsp_pin_ctrl_inst (.ref_clk(ref_clk), .sys_rst(sys_rst), .cmd_valid(cmd_valid),
      .cmd_op(cmd_op), .cmd_port(cmd_port), .cmd_line(cmd_line), .cmd_value(cmd_value),
      .cmd_spi_sel(cmd_spi_sel), .cmd_ready_ff(cmd_ready_ff), .cmd_done_ff(cmd_done_ff),
      .cmd_error_ff(cmd_error_ff), .dio_out_ff(dio_out_ff), .dio_oe_ff(dio_oe_ff),
      .sclk_o_ff(sclk_o_ff), .sclk_oe_ff(sclk_oe_ff), .mosi_o_ff(mosi_o_ff), .mosi_oe_ff(mosi_oe_ff),
      .cs_o_ff(cs_o_ff), .cs_oe_ff(cs_oe_ff));
   sdsp_pin_model sdsp_pin_model_inst (.ref_clk(ref_clk), .dio_out(dio_out_ff), .dio_oe(dio_oe_ff),
      .cs_out(cs_o_ff), .cs_oe(cs_oe_ff), .dio_pin(dio_pin), .cs_pin(cs_pin));
   // 10 MHz clock
   initial begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end
   // Closing report, reached from the main sequence or the hang guard
   task automatic test_done();
      $display("checks %0d mismatches %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // Hang guard: the whole sequence needs well under a hundred commands
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 3000) begin
         n_errors++;
         test_done();
      end
   end
   // Compare every pin group with the expected state; disabled outputs are masked
   task automatic check_all();
      `CHK("dio_out", dio_out_ff, e_out)
      `CHK("dio_oe", dio_oe_ff, e_dir)
      `CHK("dio_pin", dio_pin & e_dir, e_out & e_dir)
      `CHK("sclk_oe", sclk_oe_ff, e_sck_oe)
      `CHK("mosi_oe", mosi_oe_ff, e_sck_oe)
      `CHK("sclk_mosi", (sclk_o_ff | mosi_o_ff) & e_sck_oe, SPI_NONE)
      `CHK("cs_oe", cs_oe_ff, e_cs_oe)
      `CHK("cs_pin", cs_pin & e_cs_oe, e_cs_o & e_cs_oe)
   endtask
   // One command: hold it until taken, then expect done exactly one edge later
   task automatic send(input logic [OP_W-1:0] op, input logic [PORT_W-1:0] port, input logic [LINE_W-1:0] line,
      input logic [DIO_WIDTH-1:0] val, input logic sel, input logic err);
      int n;
      n = 0;
      cmd_valid = 1'b1;
      cmd_op = op;
      cmd_port = port;
      cmd_line = line;
      cmd_value = val;
      cmd_spi_sel = sel;
      while (cmd_ready_ff !== 1'b1 && n < 20) begin
         @(posedge ref_clk);
         #1;
         n++;
      end
      @(posedge ref_clk);
      #1;
      cmd_valid = 1'b0;
      // The cycle after the take is busy: no new command, no answer yet
      `CHK("busy", cmd_ready_ff, 1'b0)
      `CHK("early_done", cmd_done_ff, 1'b0)
      @(posedge ref_clk);
      #1;
      `CHK("done", cmd_done_ff, 1'b1)
      `CHK("ready", cmd_ready_ff, 1'b1)
      `CHK("error", cmd_error_ff, err)
      check_all();
   endtask
   // Main sequence
   initial begin
      sys_rst = 1'b1;
      cmd_valid = 1'b0;
      cmd_op = OP_WR_LINE;
      cmd_port = 2'h0;
      cmd_line = 3'h0;
      cmd_value = 8'h00;
      cmd_spi_sel = 1'b0;
      e_out = 16'h0000;
      e_dir = 16'h0000;
      e_sck_oe = SPI_NONE;
      e_cs_o = CS_ALL;
      e_cs_oe = CS_NONE;
      repeat (16) @(posedge ref_clk);
      #1;
      sys_rst = 1'b0;
      check_all();
      // Half the port as outputs, then a port write that must skip the inputs
      e_dir[7:0] = 8'h0F;
      send(OP_CFG_PORT, 2'h0, 3'h0, 8'h0F, 1'b0, 1'b0);
      e_out[7:0] = 8'h0A;
      send(OP_WR_PORT, 2'h0, 3'h0, 8'hAA, 1'b0, 1'b0);
      // Every line in turn, alternating levels, back to back
      for (int i = 0; i < 8; i++) begin
         e_out[i] = ~i[0];
         send(OP_WR_LINE, 2'h0, i[2:0], {7'h00, ~i[0]}, 1'b0, 1'b0);
      end
      // Second port chosen by number; the first must stay untouched
      e_dir[15:8] = 8'hFF;
      send(OP_CFG_PORT, 2'h1, 3'h0, 8'hFF, 1'b0, 1'b0);
      e_out[15:8] = 8'h5A;
      send(OP_WR_PORT, 2'h1, 3'h0, 8'h5A, 1'b0, 1'b0);
      // Refused port number and codes leave every pin alone
      send(OP_WR_PORT, PORT_LIMIT, 3'h0, 8'hFF, 1'b0, 1'b1);
      send(3'h6, 2'h0, 3'h0, 8'hFF, 1'b0, 1'b1);
      send(3'h7, 2'h0, 3'h0, 8'hFF, 1'b0, 1'b1);
      $display("test dio done");
      // Enable, park an active-high select low, enable the other port, then disable
      e_sck_oe[0] = 1'b1;
      e_cs_oe = CS_ALL;
      send(OP_SPI_EN, 2'h0, 3'h0, 8'h00, 1'b0, 1'b0);
      e_cs_o[3] = 1'b0;
      send(OP_CS_WR, 2'h0, 3'h3, 8'h00, 1'b0, 1'b0);
      e_sck_oe[1] = 1'b1;
      e_cs_o = CS_ALL;
      send(OP_SPI_EN, 2'h0, 3'h0, 8'h00, 1'b1, 1'b0);
      e_sck_oe[0] = 1'b0;
      e_cs_oe = CS_NONE;
      send(OP_SPI_DIS, 2'h0, 3'h0, 8'h00, 1'b0, 1'b0);
      e_sck_oe[1] = 1'b0;
      send(OP_SPI_DIS, 2'h0, 3'h0, 8'h00, 1'b1, 1'b0);
      $display("test serial done");
      // Mid-run reset drops every latch and direction, then commands work again
      sys_rst = 1'b1;
      e_out = 16'h0000;
      e_dir = 16'h0000;
      e_cs_o = CS_ALL;
      e_cs_oe = CS_NONE;
      e_sck_oe = SPI_NONE;
      repeat (2) @(posedge ref_clk);
      #1;
      `CHK("rst_ready", cmd_ready_ff, 1'b0)
      check_all();
      sys_rst = 1'b0;
      e_out[0] = 1'b1;
      send(OP_WR_LINE, 2'h0, 3'h0, 8'h01, 1'b0, 1'b0);
      $display("test reset done");
      test_done();
   end
endmodule
`default_nettype wire
